// [verilog/drc_cfg.svh]
`ifndef DRC_CFG_SVH
`define DRC_CFG_SVH

// ==========================================================================
// timing counts, in system clock cycles
// ==========================================================================
// low drive period on the soft reset pin
`define DRC_DRIVE_CYCLES  6
// wait after releasing the pin before sensing it again; covers the
// two-flop synchroniser plus the cycle in which the pin itself recovers
`define DRC_SETTLE_CYCLES 3
// width of the drive/settle counter
`define DRC_CNT_W         3
// width of the saturating drive-period counter
`define DRC_ECHO_W        8

// ==========================================================================
// reset values
// ==========================================================================
`define DRC_RST_ASSERTED  1'b0
`define DRC_RST_RELEASED  1'b1

`endif

// [verilog/drc_pkg.sv]
package drc_pkg;

   // ==========================================================================
   // soft reset pin sequencer states
   // ==========================================================================
   typedef enum logic [2:0] {
      DRC_IDLE   = 3'b001,
      DRC_DRIVE  = 3'b010,
      DRC_SETTLE = 3'b100
   } drc_state_t;

endpackage : drc_pkg

// [verilog/drc_sync.sv]
`timescale 1ns/1ps

// two-flop synchroniser with an asynchronous clear to a constant
module drc_sync (
   // clock and clear
   input  wire logic clk_in,
   input  wire logic clr_n_in,
   // data
   input  wire logic d_in,
   output logic      q_out
);

   logic meta_r;
   logic sync_r;

   // ==========================================================================
   // stages
   // ==========================================================================
   // only the second stage is visible outside
   always_ff @(posedge clk_in or negedge clr_n_in) begin
      if (!clr_n_in) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
      end else begin
         meta_r <= d_in;
         sync_r <= meta_r;
      end
   end

   assign q_out = sync_r;

endmodule : drc_sync

// [verilog/drc_top.sv]
`timescale 1ns/1ps
`include "drc_cfg.svh"

module drc_top #(
   parameter int DRIVE_CYCLES  = `DRC_DRIVE_CYCLES,
   parameter int SETTLE_CYCLES = `DRC_SETTLE_CYCLES
) (
   // clock and internal power-on reset
   input  wire logic                   clk_in,
   input  wire logic                   rst_n_in,
   // hardware reset pin
   input  wire logic                   hw_reset_n_pin_in,
   // soft reset pin, two-way
   input  wire logic                   soft_reset_n_pin_in,
   output logic                        soft_reset_n_pin_out,
   output logic                        soft_reset_n_pin_oe_out,
   // reset domains
   output logic                        por_rst_n_out,
   output logic                        core_rst_n_out,
   output logic                        dbg_rst_n_out,
   // execution and status
   output logic                        run_out,
   output logic                        exec_start_out,
   output logic                        soft_active_out,
   output logic                        soft_cause_out,
   output logic [`DRC_ECHO_W-1:0]      echo_count_out
);

   localparam logic [`DRC_CNT_W-1:0] DRIVE_LAST  = `DRC_CNT_W'(DRIVE_CYCLES - 1);
   localparam logic [`DRC_CNT_W-1:0] SETTLE_LAST = `DRC_CNT_W'(SETTLE_CYCLES - 1);
   localparam logic [`DRC_ECHO_W-1:0] ECHO_MAX   = '1;

   logic                     hw_clr_n;
   logic                     por_n;
   logic                     soft_s;
   drc_pkg::drc_state_t      state_r;
   drc_pkg::drc_state_t      state_nxt;
   logic [`DRC_CNT_W-1:0]    cnt_r;
   logic [`DRC_CNT_W-1:0]    cnt_nxt;
   logic                     core_rst_n_r;
   logic                     run_r;
   logic                     exec_start_r;
   logic                     soft_cause_r;
   logic [`DRC_ECHO_W-1:0]   echo_cnt_r;
   logic                     drive_done;
   logic                     settle_done;
   logic                     soft_active_r;
   logic                     seq_start;
   logic                     seq_end;

   // ==========================================================================
   // pin synchronisers
   // ==========================================================================
   // the hardware pin clears its synchroniser directly, so reset asserts
   // without a clock edge and releases two edges after the pin goes high
   assign hw_clr_n = rst_n_in & hw_reset_n_pin_in;

   drc_sync u_hw_sync (
      .clk_in   (clk_in),
      .clr_n_in (hw_clr_n),
      .d_in     (1'b1),
      .q_out    (por_n)
   );

   // soft pin is sampled as data; a low pin reads back through two stages
   drc_sync u_soft_sync (
      .clk_in   (clk_in),
      .clr_n_in (rst_n_in),
      .d_in     (soft_reset_n_pin_in),
      .q_out    (soft_s)
   );

   // ==========================================================================
   // soft reset pin sequencer
   // ==========================================================================
   assign drive_done  = (cnt_r == DRIVE_LAST);
   assign settle_done = (cnt_r == SETTLE_LAST);

   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      unique case (state_r)
         drc_pkg::DRC_IDLE: begin
            cnt_nxt = '0;
            if (!soft_s) begin
               state_nxt = drc_pkg::DRC_DRIVE;
            end
         end
         drc_pkg::DRC_DRIVE: begin
            if (drive_done) begin
               state_nxt = drc_pkg::DRC_SETTLE;
               cnt_nxt   = '0;
            end else begin
               cnt_nxt = cnt_r + 1'b1;
            end
         end
         drc_pkg::DRC_SETTLE: begin
            if (settle_done) begin
               cnt_nxt = '0;
               // the stale low of our own drive has flushed by now
               if (!soft_s) begin
                  state_nxt = drc_pkg::DRC_DRIVE;
               end else begin
                  state_nxt = drc_pkg::DRC_IDLE;
               end
            end else begin
               cnt_nxt = cnt_r + 1'b1;
            end
         end
         default: begin
            state_nxt = drc_pkg::DRC_IDLE;
            cnt_nxt   = '0;
         end
      endcase
   end

   // whole sequencer sits under the hardware reset domain
   always_ff @(posedge clk_in or negedge por_n) begin
      if (!por_n) begin
         state_r <= drc_pkg::DRC_IDLE;
         cnt_r   <= '0;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
      end
   end

   // ==========================================================================
   // core reset domain
   // ==========================================================================
   // held from the first low sense until the pin is seen high again
   always_ff @(posedge clk_in or negedge por_n) begin
      if (!por_n) begin
         core_rst_n_r <= `DRC_RST_ASSERTED;
      end else if (state_nxt != drc_pkg::DRC_IDLE) begin
         core_rst_n_r <= `DRC_RST_ASSERTED;
      end else begin
         core_rst_n_r <= `DRC_RST_RELEASED;
      end
   end

   // ==========================================================================
   // execution start
   // ==========================================================================
   // one pulse on the first running cycle, so a restart is seen exactly once
   always_ff @(posedge clk_in or negedge por_n) begin
      if (!por_n) begin
         run_r        <= 1'b0;
         exec_start_r <= 1'b0;
      end else begin
         run_r        <= core_rst_n_r;
         exec_start_r <= core_rst_n_r & ~run_r;
      end
   end

   // ==========================================================================
   // status kept across soft reset
   // ==========================================================================
   // sequence start for the echo counter and sequence end for the cause flag below
   assign seq_start = (state_r == drc_pkg::DRC_IDLE) && (state_nxt == drc_pkg::DRC_DRIVE);
   assign seq_end   = (state_r != drc_pkg::DRC_IDLE) && (state_nxt == drc_pkg::DRC_IDLE);

   // own flop, so the flag reads low under hardware reset instead of
   // following the asserted core reset flop
   always_ff @(posedge clk_in or negedge por_n) begin
      if (!por_n) begin
         soft_active_r <= 1'b0;
      end else begin
         soft_active_r <= (state_nxt != drc_pkg::DRC_IDLE);
      end
   end

   // cause flag lives in the power-on domain; only the hardware pin or the internal power-on reset clears it
   always_ff @(posedge clk_in or negedge por_n) begin
      if (!por_n) begin
         soft_cause_r <= 1'b0;
      end else if (seq_end) begin
         soft_cause_r <= 1'b1;
      end
   end

   // drive periods of the current soft reset event, saturating
   always_ff @(posedge clk_in or negedge por_n) begin
      if (!por_n) begin
         echo_cnt_r <= '0;
      end else if (seq_start) begin
         echo_cnt_r <= `DRC_ECHO_W'(1);
      end else if (state_r == drc_pkg::DRC_SETTLE && state_nxt == drc_pkg::DRC_DRIVE
                   && echo_cnt_r != ECHO_MAX) begin
         echo_cnt_r <= echo_cnt_r + 1'b1;
      end
   end

   // ==========================================================================
   // outputs
   // ==========================================================================
   // pin only ever sinks; the external pullup supplies the high level
   assign soft_reset_n_pin_out    = 1'b0;
   assign soft_reset_n_pin_oe_out = state_r[1];

   // power-on and debug domains ignore the soft pin
   assign por_rst_n_out   = por_n;
   assign dbg_rst_n_out   = por_n;
   // and with por_n keeps the core assert free of a clock edge
   assign core_rst_n_out  = por_n & core_rst_n_r;
   assign run_out         = run_r;
   assign exec_start_out  = exec_start_r;
   assign soft_active_out = soft_active_r;
   assign soft_cause_out  = soft_cause_r;
   assign echo_count_out  = echo_cnt_r;

endmodule : drc_top

// [dv/drc_asserts.sv]
`timescale 1ns/1ps
// ==================
// reset pin checker
module drc_asserts (
   // clock and resets
   input wire logic       clk_in,
   input wire logic       rst_n_in,
   // pins
   input wire logic       hw_reset_n_pin_in,
   input wire logic       soft_reset_n_pin_in,
   input wire logic       soft_reset_n_pin_out,
   input wire logic       soft_reset_n_pin_oe_out,
   // reset domains and execution
   input wire logic       por_rst_n_out,
   input wire logic       core_rst_n_out,
   input wire logic       dbg_rst_n_out,
   input wire logic       run_out,
   input wire logic       exec_start_out,
   input wire logic [7:0] echo_count_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in || !hw_reset_n_pin_in);
   property p_hw_hold;
      disable iff (!rst_n_in)
      !hw_reset_n_pin_in |-> !por_rst_n_out && !core_rst_n_out && !run_out;
   endproperty
   property p_boot;
      $rose(por_rst_n_out) && soft_reset_n_pin_in |=> core_rst_n_out ##1 run_out && exec_start_out;
   endproperty
   property p_sync_rel;
      $rose(por_rst_n_out) |-> $past(hw_reset_n_pin_in, 2);
   endproperty
   property p_drive_low;
      soft_reset_n_pin_oe_out |-> !soft_reset_n_pin_out;
   endproperty
   property p_hold;
      soft_reset_n_pin_oe_out |-> !core_rst_n_out;
   endproperty
   property p_spare;
      !core_rst_n_out && por_rst_n_out |-> dbg_rst_n_out;
   endproperty
   property p_len;
      $rose(soft_reset_n_pin_oe_out) |-> soft_reset_n_pin_oe_out[*6] ##1 !soft_reset_n_pin_oe_out;
   endproperty
   property p_settle;
      $fell(soft_reset_n_pin_oe_out) |-> !soft_reset_n_pin_oe_out[*3];
   endproperty
   property p_run_off;
      !core_rst_n_out |=> !run_out;
   endproperty
   a_hw_hold: assert property (p_hw_hold) else $error("reset leaked");
   a_boot: assert property (p_boot) else $error("boot order wrong");
   a_sync_rel: assert property (p_sync_rel) else $error("release not synced");
   a_drive_low: assert property (p_drive_low) else $error("pin not low");
   a_hold: assert property (p_hold) else $error("core left reset");
   a_spare: assert property (p_spare) else $error("debug reset hit");
   a_len: assert property (p_len) else $error("drive length wrong");
   a_settle: assert property (p_settle) else $error("settle too short");
   a_run_off: assert property (p_run_off) else $error("run kept");
   c_drive: cover property ($rose(soft_reset_n_pin_oe_out));
   c_start: cover property ($rose(exec_start_out));
   c_redrive: cover property (echo_count_out == 8'h02);
endmodule : drc_asserts

// [dv/drc_ext_src.sv]
`timescale 1ns/1ps
// ==================
// outside reset source on the open-drain soft reset line
module drc_ext_src (
   // clock and request to pull the line
   input  wire logic clk_in,
   input  wire logic pull_low_in,
   // device side of the line
   input  wire logic dev_out_in,
   input  wire logic dev_oe_in,
   output logic      pin_out
);
   logic hold_r = 1'b0;
   always @(negedge clk_in) hold_r <= pull_low_in;
   // wired-and; a released line rises to the pull-up level
   assign pin_out = !(hold_r || (dev_oe_in && !dev_out_in));
endmodule : drc_ext_src

// [dv/drc_tb_top.sv]
`timescale 1ns/1ps
module drc_tb_top;
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic hw_n = 1'b1;
   logic pull = 1'b0;
   logic pin, s_out, s_oe, por_n, core_n, dbg_n, run, start, act, cause;
   logic [7:0] echo;
   int fail_count = 0;
   int checks = 0;
   int n;
   always #2 clk_in = ~clk_in;
   drc_top uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .hw_reset_n_pin_in(hw_n),
      .soft_reset_n_pin_in(pin), .soft_reset_n_pin_out(s_out),
      .soft_reset_n_pin_oe_out(s_oe), .por_rst_n_out(por_n), .core_rst_n_out(core_n),
      .dbg_rst_n_out(dbg_n), .run_out(run), .exec_start_out(start),
      .soft_active_out(act), .soft_cause_out(cause), .echo_count_out(echo));
   drc_ext_src src (.clk_in(clk_in), .pull_low_in(pull), .dev_out_in(s_out),
      .dev_oe_in(s_oe), .pin_out(pin));
   task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %s exp %h got %h", name, exp, got);
      end
   endtask : chk
   task tally_and_finish;
      if (fail_count == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : tally_and_finish
   // bounded waits, at falling edges, so outputs have settled
   task to_run;
      n = 0;
      while (run !== 1'b1 && n < 200) begin
         @(negedge clk_in);
         n++;
      end
   endtask : to_run
   task to_oe(input logic lvl);
      n = 0;
      while (s_oe !== lvl && n < 200) begin
         @(negedge clk_in);
         n++;
      end
   endtask : to_oe
   // ==================
   // scenarios
   task t_boot;
      rst_n_in <= 1'b1;
      to_run;
      chk("boot_cycles", 8'h04, n[7:0]);
      chk("exec_start", 8'h01, {7'h0, start});
      @(negedge clk_in);
      chk("exec_pulse", 8'h00, {7'h0, start});
   endtask : t_boot
   task t_soft_once;
      pull <= 1'b1;
      repeat (3) @(negedge clk_in);
      pull <= 1'b0;
      to_oe(1'b1);
      n = 0;
      while (s_oe === 1'b1 && n < 50) begin
         chk("drive_pins", 8'h13, {3'h0, act, s_out, core_n, por_n, dbg_n});
         n++;
         @(negedge clk_in);
      end
      chk("drive_len", 8'h06, n[7:0]);
      to_run;
      chk("echo_once", 8'h01, echo);
      chk("cause", 8'h01, {7'h0, cause});
      chk("soft_idle", 8'h00, {7'h0, act});
   endtask : t_soft_once
   task t_soft_twice;
      pull <= 1'b1;
      to_oe(1'b1);
      to_oe(1'b0);
      to_oe(1'b1);
      chk("settle_gap", 8'h03, n[7:0]);
      pull <= 1'b0;
      to_run;
      chk("echo_twice", 8'h02, echo);
      chk("core_out", 8'h01, {7'h0, core_n});
   endtask : t_soft_twice
   task t_hw;
      hw_n <= 1'b0;
      #1;
      chk("hw_hold", 8'h00, {2'h0, act, por_n, core_n, dbg_n, run, s_oe});
      repeat (3) @(negedge clk_in);
      chk("hw_cause", 8'h00, {7'h0, cause});
      hw_n <= 1'b1;
      to_run;
      chk("hw_boot", 8'h04, n[7:0]);
   endtask : t_hw
   initial begin
      repeat (12) @(negedge clk_in);
      t_boot;
      t_soft_once;
      t_soft_twice;
      @(negedge clk_in);
      t_hw;
      tally_and_finish;
   end
   // whole run is well under a thousand cycles
   initial begin
      #20000;
      fail_count++;
      tally_and_finish;
   end
endmodule : drc_tb_top
bind drc_top drc_asserts u_chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
   .hw_reset_n_pin_in(hw_reset_n_pin_in), .soft_reset_n_pin_in(soft_reset_n_pin_in),
   .soft_reset_n_pin_out(soft_reset_n_pin_out),
   .soft_reset_n_pin_oe_out(soft_reset_n_pin_oe_out), .por_rst_n_out(por_rst_n_out),
   .core_rst_n_out(core_rst_n_out), .dbg_rst_n_out(dbg_rst_n_out), .run_out(run_out),
   .exec_start_out(exec_start_out), .echo_count_out(echo_count_out));
